// *** pkg/gdfl_pkg.sv ***
package gdfl_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 8000;
    // Least low time of the fault line in auto-reset operation
    localparam int FAULT_MIN_PULSE_NS = 3000;
    localparam int FAULT_MIN_PULSE_CYC = (FAULT_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // Least low time of reset while clearing a latched fault
    localparam int RESET_PULSE_NS = 3000;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int CNT_W = 10;

    // ****************************************
    // Configuration modes
    // ****************************************
    localparam logic [1:0] MODE_NONINV = 2'h0;
    localparam logic [1:0] MODE_INV = 2'h1;
    localparam logic [1:0] MODE_AUTO = 2'h2;

    typedef enum logic [1:0]
    {
        GDFL_RUN = 2'b00,
        GDFL_SAFE = 2'b01,
        GDFL_RESET = 2'b10,
        GDFL_WAIT = 2'b11
    } gdfl_state_e;
endpackage

// *** hdl/gdfl_host.sv ***
`timescale 1ns/1ps
module gdfl_host
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    // User side
    input wire logic [1:0] mode,
    input wire logic gate_cmd,
    input wire logic clear_req,
    output logic fault_seen,
    output logic clear_busy,
    // Device pins
    output logic noninv_gate_input,
    output logic inv_gate_input,
    output logic reset_n_pin,
    input wire logic fault_n_in,
    output logic fault_n_out,
    output logic fault_n_oe
);
    // ****************************************
    // Fault line synchroniser
    // ****************************************
    logic fsync1_r;
    logic fsync2_r;
    logic fsync1_nxt;
    logic fsync2_nxt;

    always_comb
    begin
        fsync1_nxt = fault_n_in;
        fsync2_nxt = fsync1_r;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            fsync1_r <= 1'b1;
            fsync2_r <= 1'b1;
        end
        else if (clk_en)
        begin
            fsync1_r <= fsync1_nxt;
            fsync2_r <= fsync2_nxt;
        end
    end

    // ****************************************
    // Control state
    // ****************************************
    gdfl_pkg::gdfl_state_e state_r;
    gdfl_pkg::gdfl_state_e state_nxt;
    logic [gdfl_pkg::CNT_W-1:0] cnt_r;
    logic [gdfl_pkg::CNT_W-1:0] cnt_nxt;
    logic fault_seen_r;
    logic fault_seen_nxt;
    logic noninv_r;
    logic noninv_nxt;
    logic inv_r;
    logic inv_nxt;
    logic rst_n_r;
    logic rst_n_nxt;
    logic busy_r;
    logic busy_nxt;
    logic cmd_eff;
    logic fault_now;

    assign fault_now = !fsync2_r;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        // Set wins over clear: a fault seen this cycle stays flagged
        fault_seen_nxt = fault_seen_r | fault_now;
        // A shared fault line low blocks the command in every mode
        cmd_eff = gate_cmd & !fault_now & (state_r == gdfl_pkg::GDFL_RUN);
        case (state_r)
            gdfl_pkg::GDFL_RUN:
            begin
                if (clear_req && mode != gdfl_pkg::MODE_AUTO)
                begin
                    state_nxt = gdfl_pkg::GDFL_SAFE;
                end
            end
            gdfl_pkg::GDFL_SAFE:
            begin
                // One cycle of gate-off inputs before reset falls
                state_nxt = gdfl_pkg::GDFL_RESET;
                cnt_nxt = '0;
            end
            gdfl_pkg::GDFL_RESET:
            begin
                // Pin falls one cycle after entry, so the full count is low time
                cnt_nxt = cnt_r + gdfl_pkg::CNT_W'(1);
                if (cnt_r >= gdfl_pkg::CNT_W'(gdfl_pkg::RESET_PULSE_CYC))
                begin
                    state_nxt = gdfl_pkg::GDFL_WAIT;
                end
            end
            gdfl_pkg::GDFL_WAIT:
            begin
                // Reset released; inputs stay off one more cycle
                state_nxt = gdfl_pkg::GDFL_RUN;
                fault_seen_nxt = fault_now;
            end
            default:
            begin
                state_nxt = gdfl_pkg::GDFL_RUN;
            end
        endcase
        rst_n_nxt = !(state_r == gdfl_pkg::GDFL_RESET && state_nxt == gdfl_pkg::GDFL_RESET);
        busy_nxt = (state_nxt != gdfl_pkg::GDFL_RUN);
        case (mode)
            gdfl_pkg::MODE_INV:
            begin
                noninv_nxt = !fault_now;
                inv_nxt = !cmd_eff;
            end
            gdfl_pkg::MODE_AUTO:
            begin
                noninv_nxt = cmd_eff;
                inv_nxt = 1'b0;
                // Each gate-low phase clears the device latch
                rst_n_nxt = cmd_eff;
            end
            default:
            begin
                noninv_nxt = cmd_eff;
                inv_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= gdfl_pkg::GDFL_RUN;
            cnt_r <= '0;
            fault_seen_r <= 1'b0;
            noninv_r <= 1'b0;
            inv_r <= 1'b0;
            rst_n_r <= 1'b1;
            busy_r <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            fault_seen_r <= fault_seen_nxt;
            noninv_r <= noninv_nxt;
            inv_r <= inv_nxt;
            rst_n_r <= rst_n_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ****************************************
    // Shared fault line drive
    // ****************************************
    logic line_out_r;
    logic line_out_nxt;
    logic line_oe_r;
    logic line_oe_nxt;

    always_comb
    begin
        // Host never pulls the shared line; it only listens
        line_out_nxt = 1'b0;
        line_oe_nxt = 1'b0;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            line_out_r <= 1'b0;
            line_oe_r <= 1'b0;
        end
        else if (clk_en)
        begin
            line_out_r <= line_out_nxt;
            line_oe_r <= line_oe_nxt;
        end
    end

    // ****************************************
    // Output ports
    // ****************************************
    assign fault_seen = fault_seen_r;
    assign clear_busy = busy_r;
    assign noninv_gate_input = noninv_r;
    assign inv_gate_input = inv_r;
    assign reset_n_pin = rst_n_r;
    assign fault_n_out = line_out_r;
    assign fault_n_oe = line_oe_r;
endmodule

// *** tb/gdfl_host_checker.sv ***
`timescale 1ns/1ps
module gdfl_host_checker
(
    input wire logic clock, rstn, clk_en,
    input wire logic [1:0] mode,
    input wire logic gate_cmd, clear_busy, fault_seen, fault_n_in, fault_n_oe,
    input wire logic noninv_gate_input, inv_gate_input, reset_n_pin
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic off;
    int low_r;
    assign off = !noninv_gate_input || inv_gate_input;
    // Counts only enabled edges, as a frozen clock also freezes the pulse
    always_ff @(posedge clock or negedge rstn)
        if (!rstn || reset_n_pin) low_r <= 0;
        else if (clk_en) low_r <= low_r + 1;
    noninv_pass_a: assert property ((clk_en && fault_n_in && !clear_busy && mode == 2'h0)[*4]
        |=> noninv_gate_input == $past(gate_cmd) && !inv_gate_input) else $error("noninv");
    inv_pass_a: assert property ((clk_en && fault_n_in && !clear_busy && mode == 2'h1)[*4]
        |=> noninv_gate_input && inv_gate_input == !$past(gate_cmd)) else $error("inv");
    fault_off_a: assert property ((clk_en && !fault_n_in)[*3] |=> off)
        else $error("gate on in fault");
    fault_seen_a: assert property ((clk_en && !fault_n_in && !clear_busy)[*3] |=> fault_seen)
        else $error("fault not seen");
    reset_safe_a: assert property (!reset_n_pin |-> off) else $error("reset unsafe");
    reset_len_a: assert property ($rose(reset_n_pin) && clear_busy
        |-> low_r == gdfl_pkg::RESET_PULSE_CYC) else $error("reset length");
    auto_reset_a: assert property ((clk_en && !clear_busy && mode == 2'h2)[*2]
        |-> reset_n_pin == noninv_gate_input && !inv_gate_input) else $error("auto");
    no_drive_a: assert property (!fault_n_oe) else $error("drives fault line");
endmodule
bind gdfl_host gdfl_host_checker u_chk (.clock, .rstn, .clk_en, .mode, .gate_cmd,
    .clear_busy, .fault_seen, .fault_n_in, .fault_n_oe, .noninv_gate_input,
    .inv_gate_input, .reset_n_pin);

// *** tb/gdfl_dev_model.sv ***
`timescale 1ns/1ps
module gdfl_dev_model
(
    input wire logic noninv_gate_input,
    input wire logic inv_gate_input,
    input wire logic reset_n_pin,
    input wire logic desat,
    input wire logic supply_low_lockout,
    output logic fault_line_n,
    output logic gate_drive_output
);
    // Blanking kept short so brief tests still reach a fault
    localparam realtime BLANK_NS = 16.0;
    logic latch_r = 1'b0;
    logic stretch_r = 1'b0;
    logic led;
    logic pull_up_en;
    logic strong_dn_en;
    logic soft_dn_en;
    realtime on_t = 0.0;
    assign led = noninv_gate_input && !inv_gate_input && !latch_r;
    always @(posedge led) on_t = $realtime;
    // Reset wins, so a held reset cannot relatch
    always @*
        if (!reset_n_pin) latch_r = 1'b0;
        else if (desat && led && ($realtime - on_t) >= BLANK_NS) latch_r = 1'b1;
    // Line stays low for the least pulse width even when reset clears the latch early
    always @(posedge latch_r)
    begin
        stretch_r = 1'b1;
        #(gdfl_pkg::FAULT_MIN_PULSE_NS);
        stretch_r = 1'b0;
    end
    assign fault_line_n = !(latch_r || stretch_r);
    assign gate_drive_output = led && !supply_low_lockout;
    // Zero-time model: the slow fault discharge collapses into the strong clamp
    assign soft_dn_en = 1'b0;
    assign pull_up_en = gate_drive_output;
    assign strong_dn_en = !gate_drive_output && !soft_dn_en;
endmodule

// *** tb/gdfl_host_tb.sv ***
`timescale 1ns/1ps
module gdfl_host_tb;
    logic clock = 0, rstn = 0, clk_en = 1, gate_cmd = 0, clear_req = 0, desat = 0, e = 0;
    logic supply_low_lockout = 0;
    logic [1:0] mode = 2'h0;
    logic fault_seen, clear_busy, noninv_gate_input, inv_gate_input, reset_n_pin;
    logic fault_n_in, fault_n_out, fault_n_oe, fault_line_n, gate_drive_output;
    int num_errors = 0, num_checks = 0;
    always #4 clock = ~clock;
    assign fault_n_in = fault_line_n && !(fault_n_oe && !fault_n_out);
    gdfl_host u_gdfl_host (.clock, .rstn, .clk_en, .mode, .gate_cmd, .clear_req,
        .fault_seen, .clear_busy, .noninv_gate_input, .inv_gate_input, .reset_n_pin,
        .fault_n_in, .fault_n_out, .fault_n_oe);
    gdfl_dev_model u_gdfl_dev_model (.noninv_gate_input, .inv_gate_input, .reset_n_pin,
        .desat, .supply_low_lockout, .fault_line_n, .gate_drive_output);
    task end_sim;
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic ok, input string s);
        num_checks++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, s);
        end
    endtask
    task rnd(input logic [1:0] m);
        repeat (60)
        begin
            @(negedge clock);
            if (clk_en) e = gate_cmd;
            chk(gate_drive_output === (e && !supply_low_lockout), "gate");
            mode = m;
            gate_cmd = $urandom;
            clk_en = ($urandom % 8) != 0;
            supply_low_lockout = ($urandom % 8) == 0;
        end
    endtask
    task clr;
        clear_req = 1;
        @(negedge clock);
        clear_req = 0;
        for (int i = 0; i < 400 && clear_busy; i++) @(negedge clock);
        chk(clear_busy === 1'b0 && fault_seen === 1'b0, "clear");
        repeat (2) @(negedge clock);
        chk(gate_drive_output === 1'b1, "resume");
    endtask
    task flt(input logic [1:0] m);
        {mode, gate_cmd, clk_en, supply_low_lockout} = {m, 3'h6};
        repeat (4) @(negedge clock);
        desat = 1;
        @(negedge clock);
        desat = 0;
        // Auto mode resumes only once the stretched fault pulse has ended
        repeat ((m == 2'h2) ? 400 : 6) @(negedge clock);
        chk(fault_seen === 1'b1 && gate_drive_output === (m == 2'h2), "fault");
        if (m != 2'h2) clr;
    endtask
    initial
    begin
        void'($urandom(32'hBD729DC9));
        repeat (12) @(posedge clock);
        @(negedge clock);
        rstn = 1;
        repeat (3) @(negedge clock);
        for (int m = 0; m < 4; m++) rnd(m[1:0]);
        for (int m = 0; m < 3; m++) flt(m[1:0]);
        mode = 2'h0;
        clr;
        end_sim;
    end
    initial
    begin
        #100us;
        num_errors++;
        end_sim;
    end
endmodule
